// ==== rtl/psfp_pkg.sv ====
package psfp_pkg;
    typedef enum logic [1:0] {
        PSFP_PSC_GND  = 2'b00,
        PSFP_PSC_SUP  = 2'b01,
        PSFP_PSC_DONE = 2'b10,
        PSFP_PSC_IDLE = 2'b11
    } psfp_psc_t;
    typedef logic [3:0] psfp_hb_t;
endpackage : psfp_pkg

// ==== rtl/psfp_regs.svh ====
`ifndef PSFP_REGS_SVH
`define PSFP_REGS_SVH

// number of half-bridges
`define PSFP_NHB            4
// overload counter width and maximum
`define PSFP_OLC_W          8
`define PSFP_OLC_MAX        8'h00_FF
// short check time per microfarad, in ms, and assumed filter capacitance
`define PSFP_PSC_MS_PER_UF  15
`define PSFP_PSC_CAP_UF     1
`define PSFP_CLK_MHZ        100
// cycles per short-check step: half of the total budget each
`define PSFP_PSC_STEP_CYC \
    ((`PSFP_PSC_MS_PER_UF * `PSFP_PSC_CAP_UF * 1000 * `PSFP_CLK_MHZ) / 2)
`define PSFP_PSC_CNT_W      24
// cycles without a frame start before the no-pwm fault fires
`define PSFP_NOPWM_CYC      2000
`define PSFP_NOPWM_W        12

`endif

// ==== rtl/psfp_top.sv ====
`include "psfp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module psfp_top (
    // clock and power-on reset
    input  wire logic           CLK,
    input  wire logic           NRST,
    // device reset pin from controller
    input  wire logic           RESET_PIN_N,
    // configuration
    input  wire logic           BRIDGED_PAIR_MODE,
    input  wire logic           CYCLE_CURRENT_LIMIT,
    input  wire logic           DC_PROTECT_EN,
    // per half-bridge detectors and pwm frame marks
    input  wire psfp_pkg::psfp_hb_t OVERCURRENT,
    input  wire psfp_pkg::psfp_hb_t DC_IMBALANCE,
    input  wire psfp_pkg::psfp_hb_t HIGHSIDE_CHARGE_SUPPLY_LOW,
    input  wire psfp_pkg::psfp_hb_t PWM_FRAME,
    // global detectors
    input  wire logic           SUPPLY_UNDERVOLTAGE,
    input  wire logic           TEMP_WARN,
    input  wire logic           THERMAL_SHUTDOWN,
    input  wire logic           PIN_SHORT_GND,
    input  wire logic           PIN_SHORT_SUP,
    // half-bridge controls
    output logic [3:0]          HB_HIZ,
    output logic [3:0]          HB_FLIP,
    output logic [3:0]          HB_HIGHSIDE_OFF,
    output logic                PSC_TEST_GND,
    output logic                PSC_TEST_SUP,
    output logic                RUN,
    // status pins, open drain: oe high pulls low
    output logic                FAULT_N_OE,
    output logic                THERMAL_WARNING_N_OE
);
    import psfp_pkg::*;

    // =====================================================
    // input synchronisers
    // =====================================================
    localparam int NS = 22;
    logic [NS-1:0] raw, s1_r, s2_r;
    assign raw = {RESET_PIN_N, SUPPLY_UNDERVOLTAGE, TEMP_WARN,
                  THERMAL_SHUTDOWN, PIN_SHORT_GND, PIN_SHORT_SUP,
                  OVERCURRENT, DC_IMBALANCE,
                  HIGHSIDE_CHARGE_SUPPLY_LOW, PWM_FRAME};
    always_ff @(posedge CLK) begin
        s1_r <= raw;
        s2_r <= s1_r;
    end
    wire       rst_pin   = s2_r[21];
    wire       uv        = s2_r[20];
    wire       twarn     = s2_r[19];
    wire       tsd       = s2_r[18];
    wire       sh_gnd    = s2_r[17];
    wire       sh_sup    = s2_r[16];
    wire [3:0] oc        = s2_r[15:12];
    wire [3:0] dci       = s2_r[11:8];
    wire [3:0] bst_low   = s2_r[7:4];
    wire [3:0] frm       = s2_r[3:0];

    // =====================================================
    // pin short check, once after power-on in bridged pair mode
    // =====================================================
    psfp_psc_t psc_r, psc_nxt;
    logic [`PSFP_PSC_CNT_W-1:0] psc_cnt_r, psc_cnt_nxt;
    // step length scales with filter capacitance
    localparam logic [`PSFP_PSC_CNT_W-1:0] PSC_STEP =
        `PSFP_PSC_CNT_W'(`PSFP_PSC_STEP_CYC - 1);
    wire psc_busy  = (psc_r == PSFP_PSC_GND) || (psc_r == PSFP_PSC_SUP);
    wire step_end  = (psc_cnt_r == PSC_STEP);
    always_comb begin
        psc_nxt     = psc_r;
        psc_cnt_nxt = step_end ? '0 : psc_cnt_r + 1'b1;
        case (psc_r)
            PSFP_PSC_IDLE: begin
                psc_nxt     = BRIDGED_PAIR_MODE ? PSFP_PSC_GND
                                                : PSFP_PSC_DONE;
                psc_cnt_nxt = '0;
            end
            PSFP_PSC_GND: begin
                if (sh_gnd)
                    psc_cnt_nxt = '0;
                else if (step_end)
                    psc_nxt = PSFP_PSC_SUP;
            end
            PSFP_PSC_SUP: begin
                if (sh_sup)
                    psc_cnt_nxt = '0;
                else if (step_end)
                    psc_nxt = PSFP_PSC_DONE;
            end
            PSFP_PSC_DONE: psc_cnt_nxt = '0;
            default:       psc_nxt = PSFP_PSC_IDLE;
        endcase
    end
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            psc_r     <= PSFP_PSC_IDLE;
            psc_cnt_r <= '0;
        end else begin
            psc_r     <= psc_nxt;
            psc_cnt_r <= psc_cnt_nxt;
        end
    end
    assign PSC_TEST_GND = (psc_r == PSFP_PSC_GND);
    assign PSC_TEST_SUP = (psc_r == PSFP_PSC_SUP);

    // =====================================================
    // reset pin handling
    // =====================================================
    // reset pin ignored during check
    wire dev_rst_n = rst_pin | psc_busy;
    logic rst_d_r;
    always_ff @(posedge CLK) begin
        if (!NRST)
            rst_d_r <= 1'b0;
        else
            rst_d_r <= dev_rst_n;
    end
    wire started = dev_rst_n & rst_d_r;

    // =====================================================
    // no-pwm watchdog, per half-bridge
    // =====================================================
    logic [`PSFP_NOPWM_W-1:0] npw_r [4];
    logic [3:0] nopwm;
    localparam logic [`PSFP_NOPWM_W-1:0] NOPWM_LIM =
        `PSFP_NOPWM_W'(`PSFP_NOPWM_CYC);
    always_ff @(posedge CLK) begin
        for (int i = 0; i < 4; i++) begin
            if (!NRST || frm[i])
                npw_r[i] <= '0;
            else if (npw_r[i] != NOPWM_LIM)
                npw_r[i] <= npw_r[i] + 1'b1;
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++)
            nopwm[i] = (npw_r[i] == NOPWM_LIM);
    end

    // =====================================================
    // overcurrent, overload counters and latches
    // =====================================================
    logic [`PSFP_OLC_W-1:0] olc_r [4];
    logic [3:0] olp_r, flip_r, seen_r;
    wire [3:0] dc_ev    = dci & {4{DC_PROTECT_EN}};
    // power-on and reset pin clear counters, latches
    wire       oc_clr   = !NRST || !dev_rst_n;
    wire [3:0] oc_cnt   = oc & {4{CYCLE_CURRENT_LIMIT}};
    wire [3:0] olc_up   = oc_cnt | dc_ev;
    wire [3:0] oc_trip  = oc & {4{~CYCLE_CURRENT_LIMIT}};
    // flip set on overcurrent while limiting
    wire [3:0] flip_set = oc_cnt;
    // a frame start opens a new pwm cycle; an event on it still counts
    wire [3:0] seen_nxt = oc | (seen_r & ~frm);
    wire [3:0] olc_full;
    wire [3:0] olc_zero;
    wire [3:0] olc_down;
    wire [3:0] olp_set;
    for (genvar g = 0; g < 4; g++) begin : g_olc
        assign olc_full[g] = (olc_r[g] == `PSFP_OLC_MAX);
        assign olc_zero[g] = (olc_r[g] == '0);
        assign olc_down[g] = frm[g] & ~seen_r[g] & ~olc_zero[g];
    end
    assign olp_set = olc_full | oc_trip;

    always_ff @(posedge CLK) begin
        for (int i = 0; i < 4; i++) begin
            if (oc_clr) begin
                olc_r[i]  <= '0;
                olp_r[i]  <= 1'b0;
                flip_r[i] <= 1'b0;
                seen_r[i] <= 1'b0;
            end else begin
                // flip until next frame, a new event wins
                if (flip_set[i])
                    flip_r[i] <= 1'b1;
                else if (frm[i])
                    flip_r[i] <= 1'b0;
                seen_r[i] <= seen_nxt[i];
                if (olc_up[i] && !olc_full[i])
                    olc_r[i] <= olc_r[i] + 1'b1;
                else if (!olc_up[i] && olc_down[i])
                    olc_r[i] <= olc_r[i] - 1'b1;
                if (olp_set[i])
                    olp_r[i] <= 1'b1;
            end
        end
    end

    // =====================================================
    // thermal shutdown latch
    // =====================================================
    logic tsd_r;
    always_ff @(posedge CLK) begin
        if (!NRST || !dev_rst_n)
            tsd_r <= 1'b0;
        else if (tsd)
            tsd_r <= 1'b1;
    end

    // =====================================================
    // output mapping
    // =====================================================
    // pairing chosen by BRIDGED_PAIR_MODE from setting decoder
    wire [3:0] ch_flt = olp_r | nopwm;
    wire [3:0] ch_off = BRIDGED_PAIR_MODE
        ? {{2{|ch_flt[3:2]}}, {2{|ch_flt[1:0]}}} : ch_flt;
    wire glob_off = uv | tsd_r | psc_busy | (psc_r == PSFP_PSC_IDLE);
    assign HB_HIZ   = {4{glob_off | ~started}} | ch_off;
    assign HB_FLIP  = flip_r & ~HB_HIZ;
    assign HB_HIGHSIDE_OFF = bst_low;
    assign RUN = ~(&HB_HIZ);

    wire alarm = psc_busy |
        (rst_pin & (uv | tsd_r | (|olp_r)));
    assign FAULT_N_OE           = alarm;
    assign THERMAL_WARNING_N_OE = twarn | tsd_r;

endmodule : psfp_top

`default_nettype wire

// ==== tb/psfp_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================
// controller: frames, reset pin, pull-ups
module psfp_ctrl_model (
    // clock and bench requests
    input  wire logic   clk,
    input  wire logic   hold_rst,
    input  wire logic   frame_en,
    // open-drain status, pulled up here
    input  wire logic   fault_oe,
    input  wire logic   warn_oe,
    output wire logic   fault_n,
    output wire logic   warn_n,
    // drives to the device
    output logic        reset_n,
    output psfp_pkg::psfp_hb_t frame
);
    // outputs stay unknown until the first edge; the bench holds
    // power-on reset well past that
    logic [5:0] cnt = 6'h00;
    assign fault_n = !fault_oe;
    assign warn_n = !warn_oe;
    always @(posedge clk) begin
        reset_n <= !hold_rst;
        cnt <= cnt + 6'h01;
        frame <= (cnt == 6'h3F && frame_en) ? 4'hF : 4'h0;
    end
endmodule : psfp_ctrl_model
`default_nettype wire

// ==== tb/psfp_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================
// protection checks at the top ports
module psfp_top_assertions (
    // clock and resets
    input wire logic               CLK,
    input wire logic               NRST,
    input wire logic               RESET_PIN_N,
    // mode and detectors
    input wire logic               BRIDGED_PAIR_MODE,
    input wire logic               SUPPLY_UNDERVOLTAGE,
    input wire logic               TEMP_WARN,
    input wire logic               THERMAL_SHUTDOWN,
    input wire psfp_pkg::psfp_hb_t HIGHSIDE_CHARGE_SUPPLY_LOW,
    // outputs
    input wire logic [3:0]         HB_HIZ,
    input wire logic [3:0]         HB_HIGHSIDE_OFF,
    input wire logic               PSC_TEST_GND,
    input wire logic               PSC_TEST_SUP,
    input wire logic               FAULT_N_OE,
    input wire logic               THERMAL_WARNING_N_OE
);
    import psfp_pkg::*;
    wire logic chk_busy = PSC_TEST_GND || PSC_TEST_SUP;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // four samples cover the two-flop sync plus margin; s_hot also needs the latch flop, so it has no margin
    sequence s_uv; (SUPPLY_UNDERVOLTAGE && RESET_PIN_N)[*4]; endsequence
    sequence s_hot; (THERMAL_SHUTDOWN && RESET_PIN_N)[*4]; endsequence
    a_uv_all_hiz: assert property (s_uv |-> HB_HIZ == 4'hF && FAULT_N_OE)
        else $error("undervoltage left a bridge on");
    a_hot_all_hiz: assert property (s_hot |-> HB_HIZ == 4'hF)
        else $error("thermal shutdown left a bridge on");
    a_hot_latched: assert property (s_hot ##1 RESET_PIN_N[*3] |-> HB_HIZ == 4'hF)
        else $error("thermal shutdown did not latch");
    a_warn_pin_low: assert property (TEMP_WARN[*4] |-> THERMAL_WARNING_N_OE)
        else $error("warning pin not pulled");
    a_reset_alarm_off: assert property ((!RESET_PIN_N && !chk_busy)[*4] |-> !FAULT_N_OE)
        else $error("alarm pulled during reset");
    a_check_alarm_hiz: assert property (chk_busy |-> FAULT_N_OE && HB_HIZ == 4'hF)
        else $error("short check without alarm or hi-z");
    a_check_step_order: assert property ($rose(PSC_TEST_SUP) |-> $past(PSC_TEST_GND))
        else $error("supply step not after ground step");
    a_pair_hiz_match: assert property (BRIDGED_PAIR_MODE[*4] |->
        HB_HIZ[0] == HB_HIZ[1] && HB_HIZ[2] == HB_HIZ[3])
        else $error("bridged pair split");
    a_highside_map: assert property ($stable(HIGHSIDE_CHARGE_SUPPLY_LOW)[*4] |->
        HB_HIGHSIDE_OFF == HIGHSIDE_CHARGE_SUPPLY_LOW)
        else $error("high side off mismatch");
endmodule : psfp_top_assertions
bind psfp_top psfp_top_assertions u_chk (.CLK, .NRST, .RESET_PIN_N,
    .BRIDGED_PAIR_MODE, .SUPPLY_UNDERVOLTAGE, .TEMP_WARN, .THERMAL_SHUTDOWN,
    .HIGHSIDE_CHARGE_SUPPLY_LOW, .HB_HIZ, .HB_HIGHSIDE_OFF, .PSC_TEST_GND,
    .PSC_TEST_SUP, .FAULT_N_OE, .THERMAL_WARNING_N_OE);
`default_nettype wire

// ==== tb/tb_power_stage_fault_protection.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bench
module tb_power_stage_fault_protection;
    import psfp_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, brg = 1'b0, ccl = 1'b1, dcen = 1'b0;
    logic uv = 1'b0, warn = 1'b0, tsd = 1'b0, hold = 1'b1, fren = 1'b1;
    psfp_hb_t oc = 4'h0, dc = 4'h0, bst = 4'h0;
    wire psfp_hb_t frame;
    wire logic rst_n, f_n, w_n, f_oe, w_oe;
    wire logic [3:0] hiz, flip, hso;
    wire logic run;
    int num_errors = 0, checks = 0, cycles = 0;
    always #5 clk = ~clk;
    psfp_top dut (.CLK(clk), .NRST(nrst), .RESET_PIN_N(rst_n),
        .BRIDGED_PAIR_MODE(brg), .CYCLE_CURRENT_LIMIT(ccl),
        .DC_PROTECT_EN(dcen), .OVERCURRENT(oc), .DC_IMBALANCE(dc),
        .HIGHSIDE_CHARGE_SUPPLY_LOW(bst), .PWM_FRAME(frame),
        .SUPPLY_UNDERVOLTAGE(uv), .TEMP_WARN(warn), .THERMAL_SHUTDOWN(tsd),
        .PIN_SHORT_GND(1'b0), .PIN_SHORT_SUP(1'b0), .HB_HIZ(hiz),
        .HB_FLIP(flip), .HB_HIGHSIDE_OFF(hso), .PSC_TEST_GND(),
        .PSC_TEST_SUP(), .RUN(run), .FAULT_N_OE(f_oe),
        .THERMAL_WARNING_N_OE(w_oe));
    psfp_ctrl_model u_ctrl (.clk(clk), .hold_rst(hold), .frame_en(fren),
        .fault_oe(f_oe), .warn_oe(w_oe), .fault_n(f_n), .warn_n(w_n),
        .reset_n(rst_n), .frame(frame));
    task automatic report_and_stop;
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    // pin toggle; the alarm must be released while held low
    task automatic tog;
        @(posedge clk) hold <= 1'b1;
        w(6);
        chk({f_n, w_n}, 4'h3);
        @(posedge clk) hold <= 1'b0;
        w(10);
    endtask : tog
    task automatic t_start;
        w(3);
        chk({f_n, w_n}, 4'h3);
        @(posedge clk) hold <= 1'b0;
        w(10);
        chk(hiz, 4'h0);
        chk({3'h0, run}, 4'h1);
    endtask : t_start
    task automatic t_uv;
        @(posedge clk) uv <= 1'b1;
        w(5);
        chk(hiz, 4'hF);
        chk({3'h0, run}, 4'h0);
        chk({f_n, w_n}, 4'h1);
        @(posedge clk) uv <= 1'b0;
        w(6);
        chk(hiz, 4'h0);
    endtask : t_uv
    task automatic t_heat;
        @(posedge clk) warn <= 1'b1;
        w(5);
        chk({f_n, w_n}, 4'h2);
        @(posedge clk) warn <= 1'b0;
        w(5);
        chk({f_n, w_n}, 4'h3);
        @(posedge clk) tsd <= 1'b1;
        w(5);
        chk({f_n, w_n}, 4'h0);
        @(posedge clk) tsd <= 1'b0;
        w(8);
        chk(hiz, 4'hF);
        tog();
        chk(hiz, 4'h0);
    endtask : t_heat
    task automatic t_bst;
        @(posedge clk) bst <= 4'h4;
        w(5);
        chk(hso, 4'h4);
        chk(hiz, 4'h0);
        @(posedge clk) bst <= 4'h0;
    endtask : t_bst
    task automatic t_flip;
        @(posedge frame[0]);
        @(posedge clk) oc <= 4'h1;
        @(posedge clk) oc <= 4'h0;
        w(4);
        chk(flip, 4'h1);
        w(70);
        chk(flip, 4'h0);
        chk(hiz, 4'h0);
    endtask : t_flip
    // latching mode in both pairings; no new short check on mode change
    task automatic t_latch(input logic b, input logic [3:0] hb, exp);
        @(posedge clk) brg <= b;
        ccl <= 1'b0;
        w(5);
        chk(hiz, 4'h0);
        @(posedge clk) oc <= hb;
        @(posedge clk) oc <= 4'h0;
        w(15);
        chk(hiz, exp);
        chk({f_n, w_n}, 4'h1);
        tog();
        chk(hiz, 4'h0);
    endtask : t_latch
    task automatic t_dc;
        @(posedge clk) brg <= 1'b0;
        ccl <= 1'b1;
        dc <= 4'h4;
        w(400);
        chk(hiz, 4'h0);
        @(posedge clk) dcen <= 1'b1;
        repeat (20000) if (hiz[2] !== 1'b1) @(posedge clk);
        w(2);
        chk(hiz, 4'h4);
        @(posedge clk) dc <= 4'h0;
        dcen <= 1'b0;
        tog();
    endtask : t_dc
    task automatic t_nopwm;
        @(posedge clk) fren <= 1'b0;
        w(2100);
        chk(hiz, 4'hF);
        @(posedge clk) fren <= 1'b1;
        w(80);
        chk(hiz, 4'h0);
    endtask : t_nopwm
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_start();
        t_uv();
        t_heat();
        t_bst();
        t_flip();
        t_latch(1'b1, 4'h2, 4'h3);
        t_latch(1'b0, 4'h8, 4'h8);
        t_dc();
        t_nopwm();
        report_and_stop();
    end
endmodule : tb_power_stage_fault_protection
`default_nettype wire
